// file: shared/txqr_map.svh
`ifndef TXQR_MAP_SVH
`define TXQR_MAP_SVH

// Register indices; byte address is four times the index
`define TXQR_P2_LOW_IDX 8'hce
`define TXQR_P3_HIGH_IDX 8'hd0
`define TXQR_ACTIVE_IDX 8'hd4

// Reset values: every mode bit 1, ratios 1, 2, 4 and 8
`define TXQR_P2_LOW_RST 16'h8182
`define TXQR_P3_HIGH_RST 16'h8488

// Field positions inside one 16-bit register
`define TXQR_UPPER_MODE_BIT 15
`define TXQR_UPPER_RATIO_MSB 14
`define TXQR_UPPER_RATIO_LSB 8
`define TXQR_LOWER_MODE_BIT 7
`define TXQR_LOWER_RATIO_MSB 6
`define TXQR_LOWER_RATIO_LSB 0

// Avalon response codes
`define TXQR_RESP_OKAY 2'b00
`define TXQR_RESP_SLVERR 2'b10
`define TXQR_RESP_DECERR 2'b11

// Scheduling period
`define TXQR_CLK_PERIOD_NS 10
`define TXQR_SCHED_PERIOD_NS 10000
`define TXQR_SCHED_PERIOD_CYCLES (`TXQR_SCHED_PERIOD_NS / `TXQR_CLK_PERIOD_NS)
`define TXQR_PERIOD_CNT_W 10

`endif

// file: shared/txqr_pkg.sv
package txqr_pkg;

    typedef struct packed {
        logic ratio_mode;
        logic [6:0] ratio;
    } txqr_queue_cfg_t;

    // Index 0 is queue 0 of port 2, index 3 is queue 3 of port 3
    typedef struct packed {
        txqr_queue_cfg_t [3:0] q;
    } txqr_sched_cfg_t;

    typedef enum {
        TXQR_IDLE,
        TXQR_ANSWER
    } txqr_bus_state_t;

endpackage : txqr_pkg

// file: src/txqr_period.sv
`timescale 1ns/1ps
`include "txqr_map.svh"

module txqr_period (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // One-cycle pulse at each period start
    output logic tick_q
);

    logic [`TXQR_PERIOD_CNT_W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (cnt_q == `TXQR_PERIOD_CNT_W'(`TXQR_SCHED_PERIOD_CYCLES - 1)) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + `TXQR_PERIOD_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == `TXQR_PERIOD_CNT_W'(`TXQR_SCHED_PERIOD_CYCLES - 1));
        end
    end

endmodule : txqr_period

// file: src/txqr_regs.sv
`timescale 1ns/1ps
`include "txqr_map.svh"

// Contract
// - Port 2 queue 0 mode bit 15 picks strict priority (0) or a count limit from bits 14:8 (1).
// - Bits 14:8 of the port 2 register give the queue 0 count per period, reset 1, mode reset 1.
// - Port 2 queue 1 mode bit 7 picks strict priority (0) or a count limit from bits 6:0 (1).
// - Bits 6:0 of the port 2 register give the queue 1 count per period, reset 2, mode reset 1.
// - Port 3 queue 2 mode bit 15 picks strict priority (0) or a count limit from bits 14:8 (1).
// - Bits 14:8 of the port 3 register give the queue 2 count per period, reset 4, mode reset 1.
// - Port 3 queue 3 mode bit 7 picks strict priority (0) or a count limit from bits 6:0 (1).
// - Bits 6:0 of the port 3 register give the queue 3 count per period, reset 8, mode reset 1.
module txqr_regs
    import txqr_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Avalon-MM slave
    input wire logic [9:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic [1:0] RESPONSE,
    output logic WAITREQUEST,
    // Scheduler side
    output txqr_sched_cfg_t SCHED_CFG,
    output logic PERIOD_START
);

    txqr_bus_state_t state_q;
    logic [15:0] p2_low_q;
    logic [15:0] p3_high_q;
    logic [15:0] p2_low_d;
    logic [15:0] p3_high_d;
    logic [31:0] rdata_d;
    logic [1:0] resp_d;
    logic hit_p2;
    logic hit_p3;
    logic hit_act;
    logic commit;
    logic tick;
    logic [31:0] shadow;
    txqr_queue_cfg_t live_q [4];
    localparam logic [15:0] p2_rst = `TXQR_P2_LOW_RST;
    localparam logic [15:0] p3_rst = `TXQR_P3_HIGH_RST;
    localparam logic [31:0] live_rst = {p3_rst[7:0], p3_rst[15:8], p2_rst[7:0], p2_rst[15:8]};

    txqr_period u_period (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .tick_q(tick)
    );

    assign hit_p2 = (ADDRESS[9:2] == `TXQR_P2_LOW_IDX);
    assign hit_p3 = (ADDRESS[9:2] == `TXQR_P3_HIGH_IDX);
    assign hit_act = (ADDRESS[9:2] == `TXQR_ACTIVE_IDX);
    assign commit = WRITE && (state_q == TXQR_ANSWER);

    // Answer one cycle after the request is seen; waitrequest idles high
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_q <= TXQR_IDLE;
        end else begin
            unique case (state_q)
                TXQR_IDLE: begin
                    if (READ || WRITE) begin
                        state_q <= TXQR_ANSWER;
                    end
                end
                TXQR_ANSWER: begin
                    state_q <= TXQR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            WAITREQUEST <= 1'b1;
        end else begin
            WAITREQUEST <= !((state_q == TXQR_IDLE) && (READ || WRITE));
        end
    end

    // Byte lanes 0 and 1 only; upper lanes have no storage
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        merge = old;
        if (be[0]) begin
            merge[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merge[15:8] = wd[15:8];
        end
    endfunction : merge

    always_comb begin
        p2_low_d = p2_low_q;
        p3_high_d = p3_high_q;
        if (commit && hit_p2) begin
            p2_low_d = merge(p2_low_q, WRITEDATA, BYTEENABLE);
        end
        if (commit && hit_p3) begin
            p3_high_d = merge(p3_high_q, WRITEDATA, BYTEENABLE);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            p2_low_q <= `TXQR_P2_LOW_RST;
        end else begin
            p2_low_q <= p2_low_d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            p3_high_q <= `TXQR_P3_HIGH_RST;
        end else begin
            p3_high_q <= p3_high_d;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        resp_d = `TXQR_RESP_OKAY;
        if (hit_p2) begin
            rdata_d = {16'h0000, p2_low_q};
        end else if (hit_p3) begin
            rdata_d = {16'h0000, p3_high_q};
        end else if (hit_act) begin
            rdata_d = SCHED_CFG;
            // Status view of the live copy is read only
            if (WRITE) begin
                resp_d = `TXQR_RESP_SLVERR;
            end
        end else begin
            resp_d = `TXQR_RESP_DECERR;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            READDATA <= 32'h0000_0000;
            RESPONSE <= `TXQR_RESP_OKAY;
        end else if ((state_q == TXQR_IDLE) && (READ || WRITE)) begin
            READDATA <= READ ? rdata_d : 32'h0000_0000;
            RESPONSE <= resp_d;
        end
    end

    assign shadow = {p3_high_q[7:0], p3_high_q[15:8], p2_low_q[7:0], p2_low_q[15:8]};

    // live copy moves only at a period start, so a scheduler never
    // sees a half-written pair of fields inside one period
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_queue
            always_ff @(posedge REF_CLK) begin
                if (!RST_N) begin
                    live_q[gi] <= live_rst[gi*8 +: 8];
                end else if (tick) begin
                    live_q[gi] <= shadow[gi*8 +: 8];
                end
            end
        end
    endgenerate

    assign SCHED_CFG = {live_q[3], live_q[2], live_q[1], live_q[0]};

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            PERIOD_START <= 1'b0;
        end else begin
            PERIOD_START <= tick;
        end
    end

    chk_q0_mode_load: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        tick |=> SCHED_CFG.q[0].ratio_mode == $past(p2_low_q[`TXQR_UPPER_MODE_BIT]))
        else $error("queue 0 mode not loaded at period start");

    chk_q0_reset_val: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        $rose(RST_N) |-> p2_low_q[`TXQR_UPPER_RATIO_MSB:`TXQR_UPPER_RATIO_LSB] == 7'h01
            && p2_low_q[`TXQR_UPPER_MODE_BIT] && SCHED_CFG.q[0] == 8'h81)
        else $error("queue 0 reset value wrong");

    chk_q1_mode_load: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        tick |=> SCHED_CFG.q[1].ratio_mode == $past(p2_low_q[`TXQR_LOWER_MODE_BIT]))
        else $error("queue 1 mode not loaded at period start");

    chk_q1_reset_val: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        $rose(RST_N) |-> p2_low_q[`TXQR_LOWER_RATIO_MSB:`TXQR_LOWER_RATIO_LSB] == 7'h02
            && p2_low_q[`TXQR_LOWER_MODE_BIT] && SCHED_CFG.q[1] == 8'h82)
        else $error("queue 1 reset value wrong");

    chk_q2_ratio_load: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        tick |=> SCHED_CFG.q[2] == $past(p3_high_q[15:8]))
        else $error("queue 2 fields not loaded at period start");

    chk_q2_reset_val: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        $rose(RST_N) |-> p3_high_q[15:8] == 8'h84 && SCHED_CFG.q[2] == 8'h84)
        else $error("queue 2 reset value wrong");

    chk_q3_ratio_load: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        tick |=> SCHED_CFG.q[3] == $past(p3_high_q[7:0]))
        else $error("queue 3 fields not loaded at period start");

    chk_q3_reset_val: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        $rose(RST_N) |-> p3_high_q[7:0] == 8'h88 && SCHED_CFG.q[3] == 8'h88)
        else $error("queue 3 reset value wrong");

    chk_write_readback: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        (WRITE && !WAITREQUEST && hit_p2 && BYTEENABLE[1:0] == 2'b11)
            |=> p2_low_q == $past(WRITEDATA[15:0]))
        else $error("port 2 write not stored");

    chk_live_hold: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        !tick |=> $stable(SCHED_CFG))
        else $error("live config changed inside a period");

    chk_bus_answer: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        ((READ || WRITE) && WAITREQUEST && state_q == TXQR_IDLE) |=> !WAITREQUEST ##1 WAITREQUEST)
        else $error("bus answer not one cycle");

endmodule : txqr_regs

// file: test/txqr_regs_test.sv
`timescale 1ns/1ps
`include "txqr_map.svh"

module txqr_regs_test
    import txqr_pkg::*;
;
    logic ref_clk, rst_n, rd_en, wr_en, wait_req, per_start;
    logic [9:0] addr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] be;
    logic [1:0] resp, gr;
    txqr_sched_cfg_t cfg;
    logic [15:0] m2, m3;
    int err_count, n_tests, cyc, last_tick;

    txqr_regs DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDRESS(addr), .READ(rd_en),
        .WRITE(wr_en), .WRITEDATA(wdata), .BYTEENABLE(be), .READDATA(rdata),
        .RESPONSE(resp), .WAITREQUEST(wait_req), .SCHED_CFG(cfg), .PERIOD_START(per_start));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) cyc <= cyc + 1;

    // Queue byte order on the scheduler side: q0 lowest
    function automatic logic [31:0] cfg_of(input logic [15:0] p2, input logic [15:0] p3);
        return {p3[7:0], p3[15:8], p2[7:0], p2[15:8]};
    endfunction : cfg_of

    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] d,
                                          input logic [3:0] bl);
        return {bl[1] ? d[15:8] : o[15:8], bl[0] ? d[7:0] : o[7:0]};
    endfunction : merge

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string msg);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, g, e);
        end
    endtask : chk

    // Outputs are registered, so values read right after an edge are the sampled ones
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
                       input logic [3:0] bl, output logic [31:0] rd, output logic [1:0] rs);
        int n;
        n = 0;
        addr <= a;
        wdata <= d;
        be <= bl;
        wr_en <= wr;
        rd_en <= !wr;
        @(posedge ref_clk);
        while (wait_req !== 1'b0 && n < 50) begin
            n++;
            @(posedge ref_clk);
        end
        if (n >= 50) chk(1'b1, 1'b0, "bus stall");
        rd = rdata;
        rs = resp;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        // One idle edge so the next request never lands in the same time step
        @(posedge ref_clk);
    endtask : bus

    task automatic wait_tick(output int c);
        int n;
        n = 0;
        @(posedge ref_clk);
        while (per_start !== 1'b1 && n < 1100) begin
            n++;
            @(posedge ref_clk);
        end
        if (n >= 1100) chk(1'b1, 1'b0, "no period start");
        c = cyc - last_tick;
        last_tick = cyc;
    endtask : wait_tick

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    initial begin
        #300000;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        int i, c, a;
        logic [31:0] d;
        logic [3:0] b;
        logic [15:0] p2 [2];
        logic [15:0] p3 [2];
        p2 = '{16'h7f00, 16'h80ff};
        p3 = '{16'h007f, 16'hff80};
        rst_n = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = '0;
        wdata = '0;
        be = '0;
        cyc = 0;
        err_count = 0;
        n_tests = 0;
        m2 = 16'h8182;
        m3 = 16'h8488;
        void'($urandom(83949));
        repeat (12) @(posedge ref_clk);
        chk(cfg, cfg_of(m2, m3), "reset cfg");
        rst_n <= 1'b1;
        last_tick = cyc;
        @(posedge ref_clk);
        bus(1'b0, 10'h338, '0, 4'hf, got, gr);
        chk(got, {16'h0, m2}, "reset port2");
        chk(gr, 2'b00, "resp port2");
        bus(1'b0, 10'h340, '0, 4'hf, got, gr);
        chk(got, {16'h0, m3}, "reset port3");
        $display("test reset done");
        for (i = 0; i < 16; i++) begin
            a = $urandom_range(1, 0);
            d = $urandom;
            b = $urandom_range(15, 0);
            bus(1'b1, a ? 10'h340 : 10'h338, d, b, got, gr);
            chk(gr, 2'b00, "write resp");
            if (a) m3 = merge(m3, d[15:0], b);
            else m2 = merge(m2, d[15:0], b);
            bus(1'b0, a ? 10'h340 : 10'h338, '0, 4'hf, got, gr);
            chk(got, {16'h0, a ? m3 : m2}, "readback");
        end
        $display("test random access done");
        bus(1'b1, 10'h344, 32'hffff, 4'hf, got, gr);
        chk(gr, 2'b11, "unmapped write");
        bus(1'b0, 10'h344, '0, 4'hf, got, gr);
        chk(got, 32'h0, "unmapped read data");
        chk(gr, 2'b11, "unmapped read resp");
        bus(1'b1, 10'h350, 32'hffff, 4'hf, got, gr);
        chk(gr, 2'b10, "status write");
        bus(1'b0, 10'h338, '0, 4'hf, got, gr);
        chk(got, {16'h0, m2}, "port2 kept");
        $display("test refusals done");
        // Mode bits all 0, then all 1, so both service modes reach every queue
        for (i = 0; i < 2; i++) begin
            wait_tick(c);
            bus(1'b1, 10'h338, {16'h0, p2[i]}, 4'h3, got, gr);
            bus(1'b1, 10'h340, {16'h0, p3[i]}, 4'h3, got, gr);
            chk(cfg, cfg_of(m2, m3), "cfg held");
            m2 = p2[i];
            m3 = p3[i];
            wait_tick(c);
            chk(c, `TXQR_SCHED_PERIOD_CYCLES, "period length");
            chk(cfg, cfg_of(m2, m3), "cfg loaded");
            bus(1'b0, 10'h350, '0, 4'hf, got, gr);
            chk(got, cfg_of(m2, m3), "status read");
            chk(gr, 2'b00, "status resp");
        end
        $display("test period load done");
        summarize();
    end
endmodule : txqr_regs_test
